/* File: fpd_pkg.sv */
// Summary of operation
// - Fetch reads 16-byte packets from the instruction cache, each 16-byte aligned.
// - Packet bytes are merged into a 32-byte pick window.
// - At most three instructions leave the pick window for decode per cycle.
// - Decode takes three single-op single-path instructions, or one and a half doubles.
// - A microcoded-path instruction decodes alone; no single-path partner that cycle.
// - In 64-bit mode operands are 64-bit only with REX.W; 16-bit with a 66 prefix; else 32-bit.
// - Upper eight registers need REX; original eight are reached without it.
// - In 64-bit mode a 32-bit register write clears the upper 32 bits of the register.
// - Integer load-op instructions other than the escaped shifts (0F A4/A5) stay single-path, up to three per cycle.
// - x87 ops with integer memory operand go microcoded, issuing two micro-ops.
package fpd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes of packet, window and decode budget
   localparam int         FPD_PKT_W      = 128;
   localparam int         FPD_WIN_W      = 256;
   localparam int         FPD_LINE_LSB   = 4;
   localparam logic [5:0] FPD_PKT_CNT    = 6'h10;
   localparam logic [5:0] FPD_WIN_CNT    = 6'h20;
   localparam logic [63:0] FPD_PKT_STEP  = 64'h10;
   localparam logic [2:0] FPD_UNITS_MAX  = 3'h3;
   localparam logic [1:0] FPD_UOPS_SGL   = 2'h1;
   localparam logic [1:0] FPD_UOPS_DBL   = 2'h2;
   localparam logic [1:0] FPD_UOPS_MICRO = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Encoding constants
   localparam logic [7:0] FPD_PFX_OSZ    = 8'h66;
   localparam logic [3:0] FPD_REX_HI     = 4'h4;
   localparam logic [7:0] FPD_OP_ESC     = 8'h0F;
   localparam logic [7:0] FPD_OP_ALU_END = 8'h40;
   localparam logic [3:0] FPD_OP_GRP1_HI = 4'h8;
   localparam logic [7:0] FPD_OP_IMM32   = 8'h81;
   localparam logic [4:0] FPD_OP_MOVI_HI = 5'h17;
   localparam logic [4:0] FPD_OP_X87_HI  = 5'h1B;
   localparam logic [7:0] FPD_OP_LEA     = 8'h8D;
   localparam logic [7:0] FPD_OP_GRP3    = 8'hF7;
   localparam logic [7:0] FPD_OP_GRP5    = 8'hFF;
   localparam logic [7:0] FPD_OP_SHLD_I  = 8'hA4;
   localparam logic [7:0] FPD_OP_SHLD_C  = 8'hA5;
   localparam logic [1:0] FPD_X87_INT    = 2'h2;
   localparam logic [2:0] FPD_ALU_CMP    = 3'h7;
   localparam logic [1:0] FPD_MOD_MEM0   = 2'h0;
   localparam logic [1:0] FPD_MOD_D8     = 2'h1;
   localparam logic [1:0] FPD_MOD_D32    = 2'h2;
   localparam logic [1:0] FPD_MOD_REG    = 2'h3;
   localparam logic [2:0] FPD_RM_SIB     = 3'h4;
   localparam logic [2:0] FPD_RM_DISP    = 3'h5;
   localparam logic [1:0] FPD_ALU_IMM    = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {FPD_OS16, FPD_OS32, FPD_OS64} fpd_opsize_t;
   typedef enum logic {FPD_FS_IDLE, FPD_FS_WAIT} fpd_fetch_state_t;

   typedef struct packed {
      logic        valid;
      logic        micro;
      logic [1:0]  uops;
      logic [4:0]  len;
      logic        two_byte;
      logic [7:0]  opcode;
      fpd_opsize_t opsize;
      logic [3:0]  dst_reg;
      logic        dst_gpr;
      logic        zero_upper;
      logic        load_op;
      logic [63:0] pc;
   } fpd_slot_t;

endpackage

/* File: fpd_front_end.sv */
`timescale 1ns/1ps
module fpd_front_end (
   input  wire logic                       mclk,
   input  wire logic                       sys_rst,
   input  wire logic                       mode_64,
   input  wire logic                       redirect_valid,
   input  wire logic [63:0]                redirect_addr,
   input  wire logic                       ic_valid,
   input  wire logic [127:0]               ic_data,
   input  wire logic                       dec_ready,
   output logic                            fetch_req,
   output logic [63:0]                     fetch_addr,
   output fpd_pkg::fpd_slot_t [2:0]        dec_slot
);
   import fpd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Byte picker; reads past the window return zero
   function automatic logic [7:0] fpd_byte(input logic [FPD_WIN_W-1:0] w,
                                           input logic [5:0]           i);
      fpd_byte = (i < FPD_WIN_CNT) ? w[{i[4:0], 3'h0} +: 8] : 8'h00;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Length and class decode of one instruction starting at base.
   // Every byte examined lies inside the computed length, so comparing the
   // end against the fill count is enough to know the result is trustworthy.
   function automatic fpd_slot_t fpd_decode(input logic [FPD_WIN_W-1:0] w,
                                            input logic [5:0]           base,
                                            input logic                 m64);
      fpd_slot_t  s;
      logic [5:0] p;
      logic [7:0] b;
      logic [7:0] op;
      logic [7:0] mrm;
      logic [7:0] sib;
      logic       osz;
      logic       rex;
      logic       rex_w;
      logic       rex_r;
      logic       rex_b;
      logic       has_mrm;
      logic       has_sib;
      logic       x87;
      logic       mem;
      logic       alu;
      logic [3:0] imm;
      logic [3:0] disp;
      s       = '0;
      p       = base;
      osz     = 1'b0;
      rex     = 1'b0;
      rex_w   = 1'b0;
      rex_r   = 1'b0;
      rex_b   = 1'b0;
      mrm     = 8'h00;
      sib     = 8'h00;
      imm     = 4'h0;
      disp    = 4'h0;
      b       = fpd_byte(w, p);
      if (b == FPD_PFX_OSZ) begin
         osz = 1'b1;
         p   = p + 6'h01;
         b   = fpd_byte(w, p);
      end
      // Outside 64-bit mode these bytes are one-byte opcodes
      if (m64 && b[7:4] == FPD_REX_HI) begin
         rex   = 1'b1;
         rex_w = b[3];
         rex_r = b[2];
         rex_b = b[0];
         p     = p + 6'h01;
         b     = fpd_byte(w, p);
      end
      if (b == FPD_OP_ESC) begin
         s.two_byte = 1'b1;
         p          = p + 6'h01;
      end
      op  = fpd_byte(w, p);
      p   = p + 6'h01;
      alu = !s.two_byte && op < FPD_OP_ALU_END;
      x87 = !s.two_byte && op[7:3] == FPD_OP_X87_HI;
      has_mrm = s.two_byte || (alu && !op[2]) || (!s.two_byte && op[7:4] == FPD_OP_GRP1_HI)
                || x87 || (!s.two_byte && (op == FPD_OP_GRP3 || op == FPD_OP_GRP5));
      if (has_mrm) begin
         mrm = fpd_byte(w, p);
         p   = p + 6'h01;
      end
      has_sib = has_mrm && mrm[7:6] != FPD_MOD_REG && mrm[2:0] == FPD_RM_SIB;
      if (has_sib) begin
         sib = fpd_byte(w, p);
         p   = p + 6'h01;
      end
      if (has_mrm && mrm[7:6] == FPD_MOD_D8) disp = 4'h1;
      if (has_mrm && mrm[7:6] == FPD_MOD_D32) disp = 4'h4;
      if (has_mrm && mrm[7:6] == FPD_MOD_MEM0 && (mrm[2:0] == FPD_RM_DISP
          || (has_sib && sib[2:0] == FPD_RM_DISP))) disp = 4'h4;
      // Immediates: short ALU forms, group 1, move-immediate, test
      if (alu && op[2:1] == FPD_ALU_IMM) imm = !op[0] ? 4'h1 : (osz ? 4'h2 : 4'h4);
      if (!s.two_byte && op[7:4] == FPD_OP_GRP1_HI && op[3:2] == 2'h0)
         imm = (op == FPD_OP_IMM32) ? (osz ? 4'h2 : 4'h4) : 4'h1;
      if (!s.two_byte && op[7:3] == FPD_OP_MOVI_HI)
         imm = (m64 && rex_w) ? 4'h8 : (osz ? 4'h2 : 4'h4);
      if (!s.two_byte && op == FPD_OP_GRP3 && mrm[5:3] == 3'h0)
         imm = osz ? 4'h2 : 4'h4;
      p     = p + 6'(disp) + 6'(imm);
      s.len = 5'(p - base);
      s.opcode = op;
      mem = has_mrm && mrm[7:6] != FPD_MOD_REG;
      // x87 integer-memory forms and a few others take the microcoded path
      s.micro = (x87 && mem && op[1:0] == FPD_X87_INT)
                || (!s.two_byte && op == FPD_OP_LEA && osz)
                || (s.two_byte && (op == FPD_OP_SHLD_I || op == FPD_OP_SHLD_C));
      if (s.micro) s.uops = FPD_UOPS_MICRO;
      else if (!s.two_byte && op == FPD_OP_GRP3 && mrm[5]) s.uops = FPD_UOPS_DBL;
      else s.uops = FPD_UOPS_SGL;
      // Load-op integer forms other than the escaped shifts (0F A4/A5) stay on the single path
      s.load_op = mem && !x87 && !(op == FPD_OP_LEA && !s.two_byte);
      if (m64 && rex_w) s.opsize = FPD_OS64;
      else if (osz) s.opsize = FPD_OS16;
      else s.opsize = FPD_OS32;
      // Register high bit comes only from REX, so no prefix means regs 0..7
      if (!s.two_byte && op[7:3] == FPD_OP_MOVI_HI) s.dst_reg = {rex_b, op[2:0]};
      else if ((alu && op[1]) || op == FPD_OP_LEA) s.dst_reg = {rex_r, mrm[5:3]};
      else s.dst_reg = {rex_b, mrm[2:0]};
      s.dst_gpr = !x87 && !s.two_byte && ((op[7:3] == FPD_OP_MOVI_HI) || op == FPD_OP_LEA
                  || (alu && !op[2] && (op[1] || !mem) && op[5:3] != FPD_ALU_CMP));
      s.zero_upper = m64 && s.dst_gpr && s.opsize == FPD_OS32;
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [FPD_WIN_W-1:0] win;
   logic [5:0]           cnt;
   logic [63:0]          win_pc;
   logic [3:0]           skip;
   logic                 run;
   logic                 discard;
   fpd_fetch_state_t     state;

   ////////////////////////////////////////////////////////////////////////////
   // Decode up to three candidates in a chain
   fpd_slot_t   d0;
   fpd_slot_t   d1;
   fpd_slot_t   d2;
   wire  [5:0]  end0 = 6'(d0.len);
   wire  [5:0]  end1 = end0 + 6'(d1.len);
   wire  [5:0]  end2 = end1 + 6'(d2.len);
   wire  [2:0]  u01  = 3'(d0.uops) + 3'(d1.uops);
   wire  [2:0]  u012 = u01 + 3'(d2.uops);
   assign d0 = fpd_decode(win, 6'h00, mode_64);
   assign d1 = fpd_decode(win, end0, mode_64);
   assign d2 = fpd_decode(win, end1, mode_64);

   // Pick: stop at a partial instruction, a microcoded one, or a full budget
   wire take0 = run && cnt != 6'h00 && end0 <= cnt;
   wire take1 = take0 && !d0.micro && !d1.micro && end1 <= cnt
                && u01 <= FPD_UNITS_MAX;
   wire take2 = take1 && !d2.micro && end2 <= cnt
                && u012 <= FPD_UNITS_MAX;
   wire [5:0] consumed = (!dec_ready || redirect_valid) ? 6'h00 :
                         take2 ? end2 : take1 ? end1 : take0 ? end0 : 6'h00;

   fpd_slot_t [2:0] sel;
   always_comb begin
      sel          = {d2, d1, d0};
      sel[0].valid = take0;
      sel[1].valid = take1;
      sel[2].valid = take2;
      sel[0].pc    = win_pc;
      sel[1].pc    = win_pc + 64'(end0);
      sel[2].pc    = win_pc + 64'(end1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Window merge: shift out consumed bytes, append the packet at the fill point
   wire [5:0]           rem      = cnt - consumed;
   wire [FPD_WIN_W-1:0] shifted  = win >> {consumed, 3'h0};
   wire [FPD_PKT_W-1:0] pkt      = ic_data >> {skip, 3'h0};
   wire [5:0]           pkt_len  = FPD_PKT_CNT - {2'h0, skip};
   wire                 take_pkt = ic_valid && state == FPD_FS_WAIT && !discard && !redirect_valid;
   wire [FPD_WIN_W-1:0] next_win = take_pkt ? (shifted | (FPD_WIN_W'(pkt) << {rem, 3'h0}))
                                            : shifted;
   wire [5:0]           next_cnt = take_pkt ? rem + pkt_len : rem;
   // Ask only while a whole packet still fits; fill can only drop meanwhile
   wire                 issue    = run && !redirect_valid && state == FPD_FS_IDLE
                                   && next_cnt <= FPD_PKT_CNT;

   ////////////////////////////////////////////////////////////////////////////
   // Window and pick output registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         win      <= '0;
         cnt      <= 6'h00;
         win_pc   <= 64'h0;
         dec_slot <= '0;
      end else if (redirect_valid) begin
         win      <= '0;
         cnt      <= 6'h00;
         win_pc   <= redirect_addr;
         dec_slot <= '0;
      end else begin
         win    <= next_win;
         cnt    <= next_cnt;
         win_pc <= win_pc + 64'(consumed);
         if (dec_ready) dec_slot <= sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fetch sequencer; one packet outstanding, stale replies dropped
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state      <= FPD_FS_IDLE;
         fetch_req  <= 1'b0;
         fetch_addr <= 64'h0;
         skip       <= 4'h0;
         run        <= 1'b0;
         discard    <= 1'b0;
      end else if (redirect_valid) begin
         fetch_req  <= 1'b0;
         fetch_addr <= {redirect_addr[63:FPD_LINE_LSB], 4'h0};
         skip       <= redirect_addr[3:0];
         run        <= 1'b1;
         discard    <= state == FPD_FS_WAIT && !ic_valid;
         state      <= (state == FPD_FS_WAIT && !ic_valid) ? FPD_FS_WAIT : FPD_FS_IDLE;
      end else begin
         fetch_req <= issue;
         unique case (state)
            FPD_FS_IDLE: begin
               if (issue) state <= FPD_FS_WAIT;
            end
            FPD_FS_WAIT: begin
               if (ic_valid) begin
                  state   <= FPD_FS_IDLE;
                  discard <= 1'b0;
               end
               if (take_pkt) begin
                  fetch_addr <= fetch_addr + FPD_PKT_STEP;
                  skip       <= 4'h0;
               end
            end
         endcase
      end
   end

endmodule

/* File: fpd_front_end_monitor.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Fetch ordering and the shape of every pick group
module fpd_front_end_monitor (
   input wire logic                     mclk,
   input wire logic                     sys_rst,
   input wire logic                     mode_64,
   input wire logic                     redirect_valid,
   input wire logic                     fetch_req,
   input wire logic [63:0]              fetch_addr,
   input wire fpd_pkg::fpd_slot_t [2:0] dec_slot
);
   import fpd_pkg::*;
   logic [63:0] last_addr;
   logic        have_last;
   logic [3:0]  uop_sum;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   // A redirect breaks the +16 chain, so the last request is forgotten then
   always_ff @(posedge mclk) begin
      if (sys_rst || redirect_valid) begin
         have_last <= 1'b0;
      end else if (fetch_req) begin
         have_last <= 1'b1;
         last_addr <= fetch_addr;
      end
   end
   // Micro-op total of the valid picks
   assign uop_sum = 4'(dec_slot[0].valid ? dec_slot[0].uops : 2'h0)
                  + 4'(dec_slot[1].valid ? dec_slot[1].uops : 2'h0)
                  + 4'(dec_slot[2].valid ? dec_slot[2].uops : 2'h0);
   ////////////////////////////////////////////////////////////////////////////
   a_fetch_aligned: assert property (fetch_req |-> fetch_addr[3:0] == 4'h0)
      else $error("fetch address not packet aligned");
   a_fetch_spaced: assert property ((fetch_req && !redirect_valid) |=> !fetch_req)
      else $error("second fetch while one outstanding");
   a_fetch_step: assert property (fetch_req && have_last |->
      fetch_addr == last_addr + FPD_PKT_STEP)
      else $error("fetch address not sequential");
   a_uop_budget: assert property (uop_sum <= 4'h3)
      else $error("pick group over micro-op budget");
   a_micro_alone: assert property (dec_slot[0].valid && dec_slot[0].micro |->
      !dec_slot[1].valid && !dec_slot[2].valid)
      else $error("microcoded pick has a partner");
   a_micro_uops: assert property (dec_slot[0].valid && dec_slot[0].micro |->
      dec_slot[0].uops == FPD_UOPS_MICRO)
      else $error("microcoded pick not two micro-ops");
   // Mode only changes together with a redirect, which clears the picks
   a_zero_upper: assert property (dec_slot[0].valid && !redirect_valid |->
      dec_slot[0].zero_upper == (mode_64 && dec_slot[0].dst_gpr
                                 && dec_slot[0].opsize == FPD_OS32))
      else $error("upper clear on a non 32-bit write");
   a_chain_one: assert property (dec_slot[1].valid |-> dec_slot[0].valid &&
      dec_slot[1].pc == dec_slot[0].pc + 64'(dec_slot[0].len))
      else $error("slot 1 not after slot 0");
   a_chain_two: assert property (dec_slot[2].valid |-> dec_slot[1].valid &&
      dec_slot[2].pc == dec_slot[1].pc + 64'(dec_slot[1].len))
      else $error("slot 2 not after slot 1");
endmodule

/* File: fpd_icache_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Cache stand-in: one 16-byte packet per request, after one or three cycles
module fpd_icache_model (
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic         slow,
   input  wire logic [511:0] image,
   input  wire logic         fetch_req,
   input  wire logic [63:0]  fetch_addr,
   output logic              ic_valid,
   output logic [127:0]      ic_data
);
   logic       pend;
   logic [1:0] wait_cnt;
   logic [1:0] line;
   // Data toggles when idle so stale bytes never pass for a packet
   always_ff @(posedge mclk) begin
      ic_valid <= 1'b0;
      ic_data  <= ~ic_data;
      if (sys_rst) begin
         pend    <= 1'b0;
         ic_data <= 128'h0;
      end else if (fetch_req) begin
         pend     <= 1'b1;
         wait_cnt <= slow ? 2'h2 : 2'h0;
         line     <= fetch_addr[5:4];
      end else if (pend && wait_cnt != 2'h0) begin
         wait_cnt <= wait_cnt - 2'h1;
      end else if (pend) begin
         pend     <= 1'b0;
         ic_valid <= 1'b1;
         ic_data  <= image[{line, 7'h00} +: 128];
      end
   end
endmodule

/* File: tb_fpd_front_end.sv */
`timescale 1ns/1ps
module tb_fpd_front_end;
   import fpd_pkg::*;
   logic             mclk, sys_rst, mode_64, redirect_valid, ic_valid, dec_ready, fetch_req;
   logic             slow;
   logic [63:0]      redirect_addr, fetch_addr;
   logic [127:0]     ic_data;
   logic [511:0]     image;
   fpd_slot_t [2:0]  dec_slot;
   int               num_errors, num_checks, seen_pkts;
   fpd_front_end u_fpd_front_end (.mclk(mclk), .sys_rst(sys_rst), .mode_64(mode_64),
      .redirect_valid(redirect_valid), .redirect_addr(redirect_addr), .ic_valid(ic_valid),
      .ic_data(ic_data), .dec_ready(dec_ready), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .dec_slot(dec_slot));
   fpd_icache_model u_fpd_icache_model (.mclk(mclk), .sys_rst(sys_rst), .slow(slow),
      .image(image), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .ic_valid(ic_valid),
      .ic_data(ic_data));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      if (num_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Six code bytes at addr, NOP filler elsewhere, then redirect and wait for picks
   task automatic start(input logic [63:0] addr, input logic [47:0] seq, input logic s,
                        input logic m64);
      int n;
      image = {64{8'h90}};
      for (int k = 0; k < 6; k++) image[8*(addr[5:0]+k) +: 8] = seq[8*(5-k) +: 8];
      @(posedge mclk);
      slow           <= s;
      mode_64        <= m64;
      redirect_valid <= 1'b1;
      redirect_addr  <= addr;
      @(posedge mclk);
      redirect_valid <= 1'b0;
      #1;
      n = 0;
      // The first request trails the redirect, and any stale reply it discards
      while (fetch_req !== 1'b1 && n < 10) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(fetch_req, 1'b1);
      chk(fetch_addr, {addr[63:4], 4'h0});
      seen_pkts = 0;
      n = 0;
      while (dec_slot[0].valid !== 1'b1 && n < 50) begin
         @(posedge mclk);
         #1;
         n++;
         if (ic_valid === 1'b1) seen_pkts++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic s_three_add;
      start(64'h1003, 48'h01C801C801C8, 1'b0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         chk(dec_slot[i].valid, 1'b1);
         chk(dec_slot[i].pc, 64'h1003 + 2*i);
         chk(dec_slot[i].uops, FPD_UOPS_SGL);
         chk(dec_slot[i].opsize, FPD_OS32);
         chk(dec_slot[i].zero_upper, 1'b1);
         chk(dec_slot[i].dst_gpr, 1'b1);
         chk(dec_slot[i].opcode, 8'h01);
         chk(dec_slot[i].two_byte, 1'b0);
      end
   endtask
   task automatic s_rex;
      start(64'h1010, 48'h4801C84101C8, 1'b0, 1'b1);
      chk(dec_slot[0].opsize, FPD_OS64);
      chk(dec_slot[0].zero_upper, 1'b0);
      chk(dec_slot[1].dst_reg, 4'h8);
      chk(dec_slot[0].dst_reg, 4'h0);
   endtask
   task automatic s_legacy;
      start(64'h1010, 48'h4801C84101C8, 1'b0, 1'b0);
      chk(dec_slot[0].len, 5'h1);
      chk(dec_slot[1].opsize, FPD_OS32);
      chk(dec_slot[1].zero_upper, 1'b0);
   endtask
   task automatic s_micro;
      start(64'h1020, 48'hDA0601C89090, 1'b0, 1'b1);
      chk(dec_slot[0].micro, 1'b1);
      chk(dec_slot[0].uops, FPD_UOPS_MICRO);
      chk(dec_slot[1].valid, 1'b0);
      @(posedge mclk);
      #1;
      chk(dec_slot[0].pc, 64'h1022);
      chk(dec_slot[0].micro, 1'b0);
   endtask
   // Escaped shift and 16-bit operand-size LEA both go microcoded and alone
   task automatic s_shld;
      start(64'h1000, 48'h0FA5C1668D00, 1'b0, 1'b1);
      chk(dec_slot[0].two_byte, 1'b1);
      chk(dec_slot[0].opcode, 8'hA5);
      chk(dec_slot[0].micro, 1'b1);
      chk(dec_slot[0].len, 5'h3);
      chk(dec_slot[1].valid, 1'b0);
      @(posedge mclk);
      #1;
      chk(dec_slot[0].pc, 64'h1003);
      chk(dec_slot[0].two_byte, 1'b0);
      chk(dec_slot[0].micro, 1'b1);
      chk(dec_slot[0].opsize, FPD_OS16);
      chk(dec_slot[1].valid, 1'b0);
   endtask
   // Double then single fills the budget; decode stall must hold the following group at 0x1034
   task automatic s_double;
      start(64'h1030, 48'hF7E101C8F7E1, 1'b0, 1'b1);
      chk(dec_slot[0].uops, FPD_UOPS_DBL);
      chk(dec_slot[1].valid, 1'b1);
      chk(dec_slot[2].valid, 1'b0);
      @(posedge mclk);
      dec_ready <= 1'b0;
      repeat (3) @(posedge mclk);
      dec_ready <= 1'b1;
      #1;
      chk(dec_slot[0].pc, 64'h1034);
   endtask
   task automatic s_load_op;
      start(64'h1000, 48'h030603060306, 1'b0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         chk(dec_slot[i].load_op, 1'b1);
         chk(dec_slot[i].micro, 1'b0);
      end
   endtask
   // Five-byte instruction straddling two packets, slow cache
   task automatic s_split;
      start(64'h100E, 48'hB87856341290, 1'b1, 1'b1);
      chk(seen_pkts >= 2, 1'b1);
      chk(dec_slot[0].len, 5'h5);
      chk(dec_slot[0].pc, 64'h100E);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      num_errors     = 0;
      num_checks     = 0;
      sys_rst        = 1'b1;
      mode_64        = 1'b1;
      redirect_valid = 1'b0;
      redirect_addr  = 64'h0;
      dec_ready      = 1'b1;
      slow           = 1'b0;
      image          = {64{8'h90}};
      // Sixteenth edge still samples reset, the release lands just after it
      repeat (15) @(posedge mclk);
      #1;
      chk(fetch_req, 1'b0);
      chk(fetch_addr, 64'h0);
      chk(dec_slot[0].valid, 1'b0);
      @(posedge mclk);
      sys_rst <= 1'b0;
      s_three_add();
      s_rex();
      s_micro();
      s_shld();
      s_double();
      s_load_op();
      s_split();
      s_legacy();
      end_of_test();
   end
   // Watchdog: the scenarios need well under a thousand cycles
   initial begin
      #100000;
      num_errors++;
      end_of_test();
   end
endmodule
bind fpd_front_end fpd_front_end_monitor u_fpd_front_end_monitor (.mclk(mclk),
   .sys_rst(sys_rst), .mode_64(mode_64), .redirect_valid(redirect_valid), .fetch_req(fetch_req),
   .fetch_addr(fetch_addr), .dec_slot(dec_slot));
